// ===== logic/sci_affix_mem.sv
/*
 * Small memory for header and footer characters, two banks per affix.
 * Assumes the caller keeps the read address steady for one cycle.
 */
`timescale 1ns/1ps
module sci_affix_mem (
	// Clock.
	input  wire logic       sys_clk_in,
	// Write port.
	input  wire logic       wr_en_in,
	input  wire logic [4:0] wr_addr_in,
	input  wire logic [7:0] wr_data_in,
	// Read port.
	input  wire logic [4:0] rd_addr_in,
	output logic      [7:0] rd_data_out
);
	logic [7:0] mem [32];

	always_ff @(posedge sys_clk_in) begin
		if (wr_en_in) begin
			mem[wr_addr_in] <= wr_data_in;
		end
		rd_data_out <= mem[rd_addr_in];
	end
endmodule

// ===== logic/sci_interp.sv
/*
 * Serial command interpreter: parses bracketed commands from a host byte
 * stream and frames read results as header, string and footer.
 * Assumes rx and result streams come from logic on the same clock.
 */
// Contract
// - Commands sit between a less-than and a greater-than character.
// - Letters compare case-sensitively, never folded.
// - Configuration command is one prefix letter, three digits, then fields.
// - Save-and-init trailer reinitialises and stores to nonvolatile memory.
// - Init-only trailer reinitialises without storing.
// - Every field but the last ends with a comma, no space.
// - An empty field leaves its parameter unchanged.
// - Missing trailing fields stay unchanged.
// - Back-to-back commands run in arrival order.
// - Status query returns reader status.
// - Code followed by question mark reports that command's settings.
// - Host and reader share the same serial framing settings.
// - Empty read command triggers a read, result goes back.
// - Device listens as TCP server on port 2001.
// - Result is header, decoded string, footer; defaults none and CR LF.
// - Output characters are ASCII byte codes.
`timescale 1ns/1ps
module sci_interp
	import sci_pkg::*;
(
	// Clock and reset.
	input  wire logic          sys_clk_in,
	input  wire logic          sys_rst_in,
	// Received command bytes.
	input  wire logic          rx_valid_in,
	input  wire logic [7:0]    rx_data_in,
	// Decoded read result.
	input  wire logic          res_valid_in,
	input  wire logic [7:0]    res_data_in,
	input  wire logic          res_last_in,
	output logic               res_ready_out,
	// Transmitted bytes.
	output logic               tx_valid_out,
	output logic [7:0]         tx_data_out,
	input  wire logic          tx_ready_in,
	// Configuration events.
	output logic               apply_valid_out,
	output sci_apply_type      apply_out,
	output logic               query_valid_out,
	output logic [9:0]         query_code_out,
	output logic               read_trig_out,
	output logic               init_out,
	output logic               save_out,
	output logic [15:0]        tcp_port_out
);
	sci_state_type s_q;
	sci_state_type s_d;
	logic          is_digit;
	logic          is_affix;
	logic          aff_sel;
	logic          hd_on;
	logic          ft_on;
	logic          mem_we;
	logic [4:0]    mem_waddr;
	logic [4:0]    mem_raddr;
	logic [7:0]    mem_rdata;

	assign is_digit  = (rx_data_in >= CH_ZERO) && (rx_data_in <= CH_NINE);
	assign is_affix  = (s_q.stage.code == CODE_PREAMBLE) || (s_q.stage.code == CODE_POSTAMBLE);
	assign aff_sel   = (s_q.stage.code == CODE_POSTAMBLE);
	assign hd_on     = s_q.aen[0] && (s_q.len[0] != 4'h0);
	assign ft_on     = s_q.aen[1] && (s_q.len[1] != 4'h0);
	assign mem_waddr = {aff_sel, ~s_q.bank[aff_sel], s_q.alen[2:0]};
	assign mem_raddr = (s_q.ts == T_FOOT) ? {1'b1, s_q.bank[1], s_q.idx[2:0]}
	                                      : {1'b0, s_q.bank[0], s_q.idx[2:0]};

	// Affix characters go to the idle bank so a discarded command leaves the live one intact.
	assign mem_we = rx_valid_in && (s_q.ps == P_FIELD) && is_affix && (s_q.fidx == 2'h1)
		&& (rx_data_in != CH_COMMA) && (rx_data_in != CH_CLOSE) && (rx_data_in != CH_OPEN)
		&& (rx_data_in != CH_NUL) && (s_q.alen < AFFIX_MAX);

	sci_affix_mem u_mem (
		.sys_clk_in  (sys_clk_in),
		.wr_en_in    (mem_we),
		.wr_addr_in  (mem_waddr),
		.wr_data_in  (rx_data_in),
		.rd_addr_in  (mem_raddr),
		.rd_data_out (mem_rdata)
	);

	always_comb begin
		s_d             = s_q;
		s_d.apply_valid = 1'b0;
		s_d.query_valid = 1'b0;
		s_d.read_trig   = 1'b0;
		s_d.init        = 1'b0;
		s_d.save        = 1'b0;

		// Transmit sequencer.
		unique case (s_q.ts)
			T_IDLE: begin
				if (s_q.stat_pend) begin
					s_d.stat_pend = 1'b0;
					s_d.tx_data   = CH_ZERO | {7'h00, s_q.err};
					s_d.tx_valid  = 1'b1;
					s_d.ts        = T_STAT;
				end else if (res_valid_in) begin
					s_d.ts    = T_HEAD;
					s_d.idx   = 4'h0;
					s_d.phase = 1'b0;
				end
			end
			T_STAT: begin
				if (tx_ready_in) begin
					s_d.tx_valid = 1'b0;
					s_d.ts       = T_FOOT;
					s_d.idx      = 4'h0;
					s_d.phase    = 1'b0;
				end
			end
			T_HEAD: begin
				if (s_q.tx_valid) begin
					if (tx_ready_in) begin
						s_d.tx_valid = 1'b0;
						s_d.idx      = s_q.idx + 4'h1;
					end
				end else if (!hd_on || (s_q.idx >= s_q.len[0])) begin
					s_d.ts = T_BODY;
				end else if (!s_q.phase) begin
					s_d.phase = 1'b1;
				end else begin
					s_d.tx_data  = mem_rdata;
					s_d.tx_valid = 1'b1;
					s_d.phase    = 1'b0;
				end
			end
			T_BODY: begin
				if (s_q.tx_valid) begin
					if (tx_ready_in) begin
						s_d.tx_valid = 1'b0;
						if (s_q.last) begin
							s_d.ts  = T_FOOT;
							s_d.idx = 4'h0;
						end
					end
				end else if (res_valid_in && s_q.res_ready) begin
					s_d.tx_data  = res_data_in;
					s_d.tx_valid = 1'b1;
					s_d.last     = res_last_in;
				end
			end
			T_FOOT: begin
				if (s_q.tx_valid) begin
					if (tx_ready_in) begin
						s_d.tx_valid = 1'b0;
						s_d.idx      = s_q.idx + 4'h1;
					end
				end else if (ft_on) begin
					if (s_q.idx >= s_q.len[1]) begin
						s_d.ts = T_IDLE;
					end else if (!s_q.phase) begin
						s_d.phase = 1'b1;
					end else begin
						s_d.tx_data  = mem_rdata;
						s_d.tx_valid = 1'b1;
						s_d.phase    = 1'b0;
					end
				end else if (s_q.idx >= FOOT_DEF_LEN) begin
					s_d.ts = T_IDLE;
				end else begin
					s_d.tx_data  = (s_q.idx == 4'h0) ? CH_CR : CH_LF;
					s_d.tx_valid = 1'b1;
				end
			end
		endcase
		s_d.res_ready = (s_d.ts == T_BODY) && !s_d.tx_valid;

		// Command parser; each byte is taken in arrival order.
		if (rx_valid_in) begin
			if ((rx_data_in == CH_OPEN) && (s_q.ps != P_IDLE)) begin
				s_d.err = 1'b1;
				s_d.ps  = P_OPEN;
			end else if ((rx_data_in == CH_NUL) && (s_q.ps != P_IDLE)) begin
				s_d.ps = P_SKIP;
			end else begin
				unique case (s_q.ps)
					P_IDLE: begin
						if (rx_data_in == CH_OPEN) begin
							s_d.ps = P_OPEN;
						end
					end
					P_OPEN: begin
						s_d.ps = P_TAIL;
						if (rx_data_in == CH_CFG) begin
							s_d.ps          = P_CODE;
							s_d.dig         = 2'h0;
							s_d.fidx        = 2'h0;
							s_d.val         = 16'h0000;
							s_d.got         = 1'b0;
							s_d.alen        = 4'h0;
							s_d.stage       = '0;
						end else if (rx_data_in == CH_QUERY) begin
							s_d.tail = TAIL_STAT;
						end else if (rx_data_in == CH_SAVE) begin
							s_d.tail = TAIL_SAVE;
						end else if (rx_data_in == CH_INIT) begin
							s_d.tail = TAIL_INIT;
						end else if (rx_data_in == CH_SPACE) begin
							s_d.tail = TAIL_READ;
						end else if (rx_data_in == CH_CLOSE) begin
							s_d.ps = P_IDLE;
						end else begin
							s_d.ps = P_SKIP;
						end
					end
					P_CODE: begin
						if (is_digit && (s_q.dig != CODE_DIGITS)) begin
							s_d.stage.code = 10'((s_q.stage.code << 3) + (s_q.stage.code << 1)
								+ {6'h00, rx_data_in[3:0]});
							s_d.dig = s_q.dig + 2'h1;
						end else if ((s_q.dig == CODE_DIGITS) && sci_code_known(s_q.stage.code)) begin
							if (rx_data_in == CH_COMMA) begin
								s_d.ps = P_FIELD;
							end else if (rx_data_in == CH_QUERY) begin
								s_d.ps   = P_TAIL;
								s_d.tail = TAIL_QUERY;
							end else if (rx_data_in == CH_CLOSE) begin
								s_d.ps = P_IDLE;
							end else begin
								s_d.ps = P_SKIP;
							end
						end else begin
							s_d.ps = P_SKIP;
						end
					end
					P_FIELD: begin
						if ((rx_data_in == CH_COMMA) || (rx_data_in == CH_CLOSE)) begin
							// Only fields that carried digits are marked; empty ones stay as they are.
							if (s_q.got && (s_q.fidx != FIELD_OVER)) begin
								s_d.stage.value[s_q.fidx] = s_q.val;
								s_d.stage.mask[s_q.fidx]  = 1'b1;
							end
							s_d.val = 16'h0000;
							s_d.got = 1'b0;
							if (s_q.fidx != FIELD_OVER) begin
								s_d.fidx = s_q.fidx + 2'h1;
							end
							if (rx_data_in == CH_CLOSE) begin
								// Trailing fields not sent keep their mask bit clear.
								s_d.ps          = P_IDLE;
								s_d.apply_valid = 1'b1;
								s_d.apply       = s_d.stage;
								s_d.err         = 1'b0;
								if (is_affix) begin
									if (s_d.stage.mask[0]) begin
										s_d.aen[aff_sel] = s_d.stage.value[0][0];
									end
									if (s_q.alen != 4'h0) begin
										s_d.bank[aff_sel] = ~s_q.bank[aff_sel];
										s_d.len[aff_sel]  = s_q.alen;
									end
								end
							end
						end else if (mem_we) begin
							s_d.alen = s_q.alen + 4'h1;
						end else if (is_digit && !(is_affix && (s_q.fidx == 2'h1))) begin
							s_d.val = 16'((s_q.val << 3) + (s_q.val << 1) + {12'h000, rx_data_in[3:0]});
							s_d.got = 1'b1;
						end else if (!(is_affix && (s_q.fidx == 2'h1))) begin
							s_d.ps = P_SKIP;
						end
					end
					P_TAIL: begin
						if (rx_data_in == CH_CLOSE) begin
							s_d.ps = P_IDLE;
							// A status query reports the command before it, so it keeps the flag.
							if (s_q.tail != TAIL_STAT) begin
								s_d.err = 1'b0;
							end
							unique case (s_q.tail)
								TAIL_STAT:  s_d.stat_pend = 1'b1;
								TAIL_SAVE: begin
									s_d.init = 1'b1;
									s_d.save = 1'b1;
								end
								TAIL_INIT:  s_d.init = 1'b1;
								TAIL_READ:  s_d.read_trig = 1'b1;
								TAIL_QUERY: begin
									s_d.query_valid = 1'b1;
									s_d.query_code  = s_q.stage.code;
								end
								default:    s_d.err = 1'b1;
							endcase
						end else begin
							s_d.ps = P_SKIP;
						end
					end
					P_SKIP: begin
						if (rx_data_in == CH_CLOSE) begin
							s_d.ps  = P_IDLE;
							s_d.err = 1'b1;
						end
					end
				endcase
			end
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			s_q          <= '0;
			s_q.ps       <= P_IDLE;
			s_q.ts       <= T_IDLE;
			s_q.tcp_port <= TCP_PORT_DEFAULT;
		end else begin
			s_q <= s_d;
		end
	end

	assign res_ready_out   = s_q.res_ready;
	assign tx_valid_out    = s_q.tx_valid;
	assign tx_data_out     = s_q.tx_data;
	assign apply_valid_out = s_q.apply_valid;
	assign apply_out       = s_q.apply;
	assign query_valid_out = s_q.query_valid;
	assign query_code_out  = s_q.query_code;
	assign read_trig_out   = s_q.read_trig;
	assign init_out        = s_q.init;
	assign save_out        = s_q.save;
	assign tcp_port_out    = s_q.tcp_port;

	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (sys_rst_in);

	AST_SAVE_WITH_INIT: assert property (save_out |-> init_out)
		else $error("save issued without init");
	AST_INIT_CAUSE: assert property (init_out |-> $past(rx_valid_in)
		&& ($past(rx_data_in) == CH_CLOSE) && ($past(s_q.ps) == P_TAIL))
		else $error("init not caused by a closed trailer");
	AST_APPLY_CLOSE: assert property (apply_valid_out |-> $past(rx_valid_in)
		&& ($past(rx_data_in) == CH_CLOSE))
		else $error("apply not on a closing delimiter");
	AST_APPLY_KNOWN: assert property (apply_valid_out |-> sci_code_known(apply_out.code))
		else $error("apply for unknown code");
	AST_NUL_SKIP: assert property ((rx_valid_in && (rx_data_in == CH_NUL)
		&& (s_q.ps != P_IDLE)) |=> (s_q.ps == P_SKIP) && !apply_valid_out)
		else $error("null byte not discarded");
	AST_READ_PULSE: assert property (read_trig_out |=> !read_trig_out)
		else $error("read trigger longer than one cycle");
	AST_TCP_PORT: assert property (tcp_port_out == TCP_PORT_DEFAULT)
		else $error("tcp port not default");
	AST_TX_HOLD: assert property ((tx_valid_out && !tx_ready_in)
		|=> tx_valid_out && $stable(tx_data_out))
		else $error("tx byte dropped before accept");
	AST_DEF_FOOT: assert property ((tx_valid_out && tx_ready_in && (tx_data_out == CH_CR)
		&& (s_q.ts == T_FOOT) && !ft_on) |=> ##[1:2] (tx_valid_out && (tx_data_out == CH_LF)))
		else $error("default footer LF missing after CR");
	AST_QUERY_CODE: assert property (query_valid_out |-> $past(s_q.ps) == P_TAIL)
		else $error("query without code and question mark");
endmodule

// ===== logic/sci_pkg.sv
/*
 * Shared constants and types of the serial command interpreter.
 * Assumes one system clock; byte streams arrive already deframed.
 */
package sci_pkg;
	localparam logic [7:0] CH_NUL   = 8'h00;
	localparam logic [7:0] CH_CR    = 8'h0d;
	localparam logic [7:0] CH_LF    = 8'h0a;
	localparam logic [7:0] CH_SPACE = 8'h20;
	localparam logic [7:0] CH_COMMA = 8'h2c;
	localparam logic [7:0] CH_ZERO  = 8'h30;
	localparam logic [7:0] CH_NINE  = 8'h39;
	localparam logic [7:0] CH_OPEN  = 8'h3c;
	localparam logic [7:0] CH_CLOSE = 8'h3e;
	localparam logic [7:0] CH_QUERY = 8'h3f;
	localparam logic [7:0] CH_INIT  = 8'h41;
	localparam logic [7:0] CH_CFG   = 8'h4b;
	localparam logic [7:0] CH_SAVE  = 8'h5a;

	localparam logic [15:0] TCP_PORT_DEFAULT = 16'h07d1;
	localparam logic [1:0]  CODE_DIGITS      = 2'h3;
	localparam logic [1:0]  FIELD_OVER       = 2'h3;
	localparam logic [3:0]  AFFIX_MAX        = 4'h8;
	localparam logic [3:0]  FOOT_DEF_LEN     = 4'h2;
	localparam logic [9:0]  CODE_PREAMBLE    = 10'h08d;
	localparam logic [9:0]  CODE_POSTAMBLE   = 10'h08e;

	localparam logic [2:0] TAIL_STAT  = 3'h0;
	localparam logic [2:0] TAIL_SAVE  = 3'h1;
	localparam logic [2:0] TAIL_INIT  = 3'h2;
	localparam logic [2:0] TAIL_READ  = 3'h3;
	localparam logic [2:0] TAIL_QUERY = 3'h4;

	typedef enum logic [5:0] {
		P_IDLE  = 6'h01,
		P_OPEN  = 6'h02,
		P_CODE  = 6'h04,
		P_FIELD = 6'h08,
		P_TAIL  = 6'h10,
		P_SKIP  = 6'h20
	} sci_parse_type;

	typedef enum logic [4:0] {
		T_IDLE = 5'h01,
		T_STAT = 5'h02,
		T_HEAD = 5'h04,
		T_BODY = 5'h08,
		T_FOOT = 5'h10
	} sci_tx_type;

	typedef struct packed {
		logic [9:0]       code;
		logic [2:0]       mask;
		logic [2:0][15:0] value;
	} sci_apply_type;

	typedef struct packed {
		sci_parse_type ps;
		logic [2:0]    tail;
		logic [1:0]    dig;
		logic [1:0]    fidx;
		logic [15:0]   val;
		logic          got;
		logic [3:0]    alen;
		logic [1:0]    bank;
		logic [1:0]    aen;
		logic [1:0][3:0] len;
		logic          err;
		logic          stat_pend;
		sci_tx_type    ts;
		logic          phase;
		logic          last;
		logic [3:0]    idx;
		sci_apply_type stage;
		logic          apply_valid;
		sci_apply_type apply;
		logic          query_valid;
		logic [9:0]    query_code;
		logic          read_trig;
		logic          init;
		logic          save;
		logic          tx_valid;
		logic [7:0]    tx_data;
		logic          res_ready;
		logic [15:0]   tcp_port;
	} sci_state_type;

	function automatic logic sci_code_known(input logic [9:0] c);
		case (c)
			10'h064, 10'h07e, 10'h07f, 10'h080, 10'h081, 10'h08c, 10'h08d,
			10'h08e, 10'h08f, 10'h091, 10'h093, 10'h094, 10'h095, 10'h0a3,
			10'h0a4, 10'h0a6, 10'h384: sci_code_known = 1'b1;
			default: sci_code_known = 1'b0;
		endcase
	endfunction
endpackage

// ===== testbench/sci_host_model.sv
/*
 * Host model: sends queued command bytes one per cycle and sinks reply bytes.
 * Assumes the interpreter runs on the same clock as this model.
 */
`timescale 1ns/1ps
module sci_host_model (
	// Clock and reset.
	input  wire logic       sys_clk_in,
	input  wire logic       sys_rst_in,
	// Stall control.
	input  wire logic       slow_in,
	// Command bytes.
	output logic            rx_valid_out,
	output logic      [7:0] rx_data_out,
	// Reply bytes.
	input  wire logic       tx_valid_in,
	input  wire logic [7:0] tx_data_in,
	output logic            tx_ready_out
);
	logic [7:0] send_q[$];
	logic [7:0] got_q[$];

	initial begin
		rx_valid_out = 1'b0;
		rx_data_out  = 8'h00;
		tx_ready_out = 1'b0;
	end

	// Idle data flips every cycle so a stale byte never looks valid.
	always @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			rx_valid_out <= 1'b0;
			tx_ready_out <= 1'b0;
		end else begin
			if (send_q.size() > 0) begin
				rx_valid_out <= 1'b1;
				rx_data_out  <= send_q.pop_front();
			end else begin
				rx_valid_out <= 1'b0;
				rx_data_out  <= ~rx_data_out;
			end
			if (tx_valid_in && tx_ready_out) begin
				got_q.push_back(tx_data_in);
			end
			tx_ready_out <= slow_in ? ~tx_ready_out : 1'b1;
		end
	end
endmodule

// ===== testbench/test_sci_interp.sv
/*
 * Self-checking testbench of the serial command interpreter.
 * Assumes a 10 MHz clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
module test_sci_interp
	import sci_pkg::*;
();
	logic          clk = 1'b0;
	logic          rst = 1'b1;
	logic          slow = 1'b0;
	logic          res_valid = 1'b0;
	logic [7:0]    res_data = 8'h00;
	logic          res_last = 1'b0;
	logic          rx_valid;
	logic [7:0]    rx_data;
	logic          res_ready;
	logic          tx_valid;
	logic [7:0]    tx_data;
	logic          tx_ready;
	logic          apply_valid;
	sci_apply_type apply;
	logic          query_valid;
	logic [9:0]    query_code;
	logic          read_trig;
	logic          init;
	logic          save;
	logic [15:0]   tcp_port;
	sci_apply_type aq[$];
	logic [9:0]    qq[$];
	int            n_init;
	int            n_save;
	int            n_read;
	int            checks = 0;
	int            bad_count = 0;

	always #50 clk = ~clk;

	sci_host_model u_sci_host_model (
		.sys_clk_in  (clk),
		.sys_rst_in  (rst),
		.slow_in     (slow),
		.rx_valid_out(rx_valid),
		.rx_data_out (rx_data),
		.tx_valid_in (tx_valid),
		.tx_data_in  (tx_data),
		.tx_ready_out(tx_ready)
	);

	sci_interp u_sci_interp (
		.sys_clk_in     (clk),
		.sys_rst_in     (rst),
		.rx_valid_in    (rx_valid),
		.rx_data_in     (rx_data),
		.res_valid_in   (res_valid),
		.res_data_in    (res_data),
		.res_last_in    (res_last),
		.res_ready_out  (res_ready),
		.tx_valid_out   (tx_valid),
		.tx_data_out    (tx_data),
		.tx_ready_in    (tx_ready),
		.apply_valid_out(apply_valid),
		.apply_out      (apply),
		.query_valid_out(query_valid),
		.query_code_out (query_code),
		.read_trig_out  (read_trig),
		.init_out       (init),
		.save_out       (save),
		.tcp_port_out   (tcp_port)
	);

	always @(posedge clk) begin
		if (!rst) begin
			if (apply_valid === 1'b1) aq.push_back(apply);
			if (query_valid === 1'b1) qq.push_back(query_code);
			if (init === 1'b1) n_init++;
			if (save === 1'b1) n_save++;
			if (read_trig === 1'b1) n_read++;
		end
	end

	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task complete_run;
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task clr;
		aq.delete();
		qq.delete();
		n_init = 0;
		n_save = 0;
		n_read = 0;
		u_sci_host_model.got_q.delete();
	endtask

	// Queues a string for the host and waits until it has left plus the answer delay.
	task send(input string s);
		int i;
		for (i = 0; i < s.len(); i++) u_sci_host_model.send_q.push_back(s[i]);
		for (i = 0; i < 300 && u_sci_host_model.send_q.size() > 0; i++) begin
			@(posedge clk);
			#1;
		end
		if (i == 300) begin
			bad_count++;
			complete_run();
		end else begin
			repeat (4) @(posedge clk);
			#1;
		end
	endtask

	// Waits for n reply bytes, then makes sure no further byte follows.
	task wait_tx(input int n);
		int k;
		for (k = 0; k < 300 && u_sci_host_model.got_q.size() < n; k++) @(posedge clk);
		if (k == 300) begin
			bad_count++;
			complete_run();
		end else begin
			repeat (8) @(posedge clk);
			chk("tx_count", u_sci_host_model.got_q.size(), n);
		end
	endtask

	function automatic logic [31:0] got(input int n);
		logic [31:0] w;
		w = 32'h0;
		for (int i = 0; i < n; i++) w = {w[23:0], u_sci_host_model.got_q[i]};
		return w;
	endfunction

	task drive_res(input string s);
		int i;
		int k;
		@(posedge clk);
		for (i = 0; i < s.len(); i++) begin
			res_valid <= 1'b1;
			res_data  <= s[i];
			res_last  <= (i == s.len() - 1);
			for (k = 0; k < 50; k++) begin
				@(posedge clk);
				if (res_ready === 1'b1) break;
			end
			if (k == 50) begin
				bad_count++;
				complete_run();
			end
		end
		res_valid <= 1'b0;
		res_last  <= 1'b0;
	endtask

	task t_apply;
		clr();
		send("<K100,3>");
		chk("apply_n", aq.size(), 1);
		chk("code", aq[0].code, 10'h064);
		chk("mask", aq[0].mask, 3'h1);
		chk("val0", aq[0].value[0], 16'h0003);
		clr();
		send("<K145,,7>");
		chk("mask", aq[0].mask, 3'h2);
		chk("val1", aq[0].value[1], 16'h0007);
		$display("test apply done");
	endtask

	task t_concat;
		clr();
		send("<K145,1><K143,25><A>");
		chk("apply_n", aq.size(), 2);
		chk("code0", aq[0].code, 10'h091);
		chk("code1", aq[1].code, 10'h08f);
		chk("val", aq[1].value[0], 16'h0019);
		chk("init", n_init, 1);
		chk("save", n_save, 0);
		clr();
		send("<Z>");
		chk("init", n_init, 1);
		chk("save", n_save, 1);
		$display("test concat done");
	endtask

	task t_bad;
		clr();
		u_sci_host_model.send_q.push_back(CH_OPEN);
		u_sci_host_model.send_q.push_back(CH_NUL);
		send("<k100,3><K100,3 ,1><K999,1><K10");
		send("<?>");
		chk("apply_n", aq.size(), 0);
		wait_tx(3);
		chk("status", got(3), 32'h00310d0a);
		clr();
		send("<K100,3><?>");
		wait_tx(3);
		chk("status", got(3), 32'h00300d0a);
		$display("test bad done");
	endtask

	task t_query;
		clr();
		send("<K142?>");
		chk("query_n", qq.size(), 1);
		chk("query", qq[0], 10'h08e);
		chk("apply_n", aq.size(), 0);
		$display("test query done");
	endtask

	task t_read;
		clr();
		slow <= 1'b1;
		send("< >");
		chk("read", n_read, 1);
		drive_res("12");
		wait_tx(4);
		chk("result", got(4), 32'h31320d0a);
		clr();
		send("<K141,1,H><K142,1,AB>");
		chk("apply_n", aq.size(), 2);
		drive_res("9");
		wait_tx(4);
		chk("affix", got(4), 32'h48394142);
		slow <= 1'b0;
		$display("test read done");
	endtask

	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		chk("tcp_port", tcp_port, 32'h000007d1);
		t_apply();
		t_concat();
		t_bad();
		t_query();
		t_read();
		complete_run();
	end
endmodule
